/* core/tmh_defs.svh */
// Offsets, field positions, reset values and divider figures of the interval/PWM timer
`ifndef TMH_DEFS_SVH
`define TMH_DEFS_SVH

`define TMH_IDX_PERIOD 16'hFF0E
`define TMH_IDX_DUTY   16'hFF0F
`define TMH_IDX_MODE   16'hFF70
`define TMH_IDX_STATUS 16'hFF71
`define TMH_IDX_COUNT  16'hFF72

`define TMH_ADDR_PERIOD ({14'h0000, `TMH_IDX_PERIOD, 2'h0})
`define TMH_ADDR_DUTY   ({14'h0000, `TMH_IDX_DUTY, 2'h0})
`define TMH_ADDR_MODE   ({14'h0000, `TMH_IDX_MODE, 2'h0})
`define TMH_ADDR_STATUS ({14'h0000, `TMH_IDX_STATUS, 2'h0})
`define TMH_ADDR_COUNT  ({14'h0000, `TMH_IDX_COUNT, 2'h0})

`define TMH_RST_BYTE 8'h00

`define TMH_EN_BIT     7
`define TMH_CKS_MSB    6
`define TMH_CKS_LSB    4
`define TMH_PWM_BIT    3
`define TMH_LEV_BIT    1
`define TMH_OEN_BIT    0

`define TMH_CKS_DIV1    3'h0
`define TMH_CKS_DIV4    3'h1
`define TMH_CKS_DIV16   3'h2
`define TMH_CKS_DIV64   3'h3
`define TMH_CKS_DIV4096 3'h4
`define TMH_CKS_LSO128  3'h5

`define TMH_EXP_DIV4    2
`define TMH_EXP_DIV16   4
`define TMH_EXP_DIV64   6
`define TMH_EXP_DIV4096 12
`define TMH_EXP_LSO     7
`define TMH_SYNC_N      3

`endif

/* core/tmh_pkg.sv */
// Types shared by the interval/PWM timer modules
`include "tmh_defs.svh"

package tmh_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } tmh_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } tmh_apb_rsp_t;

    typedef enum logic [1:0] {
        TMH_STOP  = 2'b00,
        TMH_ARMED = 2'b01,
        TMH_RUN   = 2'b10
    } tmh_phase_t;

    typedef enum logic {
        TMH_CMP_PERIOD = 1'b0,
        TMH_CMP_DUTY   = 1'b1
    } tmh_cmp_t;

    typedef struct packed {
        logic [7:0]  mode;
        logic [7:0]  period;
        logic [7:0]  duty_act;
        logic [7:0]  duty_buf;
        logic        pend;
        tmh_phase_t  phase;
        tmh_cmp_t    cmp;
        logic [7:0]  count;
        logic        active;
        logic        irq;
        logic        pin;
        logic [31:0] rdata;
        logic        slverr;
    } tmh_state_t;

    typedef struct packed {
        logic [`TMH_EXP_DIV4096-1:0] div;
        logic [`TMH_EXP_LSO-1:0]     lso_div;
        logic [`TMH_SYNC_N-1:0]      sync;
        logic                        lso_lvl;
    } tmh_pre_t;

endpackage

/* core/tmh_prescaler.sv */
// Count clock prescaler: peripheral clock dividers and synchronised slow oscillator divider
`include "tmh_defs.svh"

module tmh_prescaler (
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       sys_rst_i,
    // Control
    input  wire logic       run_i,
    input  wire logic [2:0] sel_i,
    input  wire logic       lso_clk_i,
    // Count clock
    output logic            tick_o
);

    tmh_pkg::tmh_pre_t st;
    tmh_pkg::tmh_pre_t next_st;
    logic              lso_edge;

    always_comb begin
        next_st = st;
        // Stage 0 feeds stage 1 only; stages 1 and 2 must agree
        next_st.sync = {st.sync[1:0], lso_clk_i};
        if (st.sync[2] == st.sync[1]) begin
            next_st.lso_lvl = st.sync[2];
        end
        lso_edge = next_st.lso_lvl & ~st.lso_lvl;
        // Cleared while stopped so the first tick lands within one count period
        if (!run_i) begin
            next_st.div     = '0;
            next_st.lso_div = '0;
        end else begin
            next_st.div = st.div + 1'b1;
            if (lso_edge) begin
                next_st.lso_div = st.lso_div + 1'b1;
            end
        end
        case (sel_i)
            `TMH_CKS_DIV1:    tick_o = run_i; // see RULE_06
            `TMH_CKS_DIV4:    tick_o = run_i & (&st.div[`TMH_EXP_DIV4-1:0]);
            `TMH_CKS_DIV16:   tick_o = run_i & (&st.div[`TMH_EXP_DIV16-1:0]);
            `TMH_CKS_DIV64:   tick_o = run_i & (&st.div[`TMH_EXP_DIV64-1:0]);
            `TMH_CKS_DIV4096: tick_o = run_i & (&st.div);
            `TMH_CKS_LSO128:  tick_o = run_i & lso_edge & (&st.lso_div);
            // Prohibited codes give no count clock
            default:          tick_o = 1'b0;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule

/* core/tmh_timer.sv */
// Eight-bit interval / PWM timer with APB register slave
//
// Notes on behaviour
// RULE_01: Reset clears compare and mode registers; byte access.
// RULE_02: Software leaves period alone while counting.
// RULE_03: Running duty writes wait in buffer for match.
// RULE_04: Write colliding with duty match waits one more.
// RULE_05: Enable starts counting; disable stops, zeroes counter.
// RULE_06: Clock select picks divided peripheral or slow clock.
// RULE_07: Mode field selects interval or PWM operation.
// RULE_08: Level bit sets the inactive output level.
// RULE_09: Output enable bit gates the waveform onto pin.
// RULE_10: Software keeps mode bits still while enabled.
// RULE_11: Software rewrites duty after every PWM restart.
// RULE_12: Interval match raises interrupt, clears counter.
// RULE_13: Interval mode ignores the duty compare value.
// RULE_14: Interval match toggles output, fifty percent duty.
// RULE_15: Counting begins within one count clock.
// RULE_16: Disable forces interrupt and output inactive.
// RULE_17: PWM period match clears, interrupts, activates output.
// RULE_18: PWM duty match deactivates output, no clear.
// RULE_19: PWM period N plus one, width M plus one.
// RULE_20: Software leaves three count clocks before transfer.
// RULE_21: Software keeps duty below period in PWM.
// RULE_22: First count clock masked; output stays inactive.
// RULE_23: Match interrupt is a single cycle pulse.
// RULE_24: Disabled output sits at the default level.
`include "tmh_defs.svh"

module tmh_timer (
    // Clock and reset
    input  wire logic                 clock_i,
    input  wire logic                 sys_rst_i,
    // APB slave
    input  wire tmh_pkg::tmh_apb_req_t apb_req_i,
    output tmh_pkg::tmh_apb_rsp_t      apb_rsp_o,
    // Slow oscillator from another domain
    input  wire logic                 lso_clk_i,
    // Timer pin and match event
    output logic                      timer_out_o,
    output logic                      match_irq_o
);

    tmh_pkg::tmh_state_t st;
    tmh_pkg::tmh_state_t next_st;

    logic       tick;
    logic       run;
    logic       pwm;
    logic       setup;
    logic       wr;
    logic       hit_period;
    logic       hit_duty;
    logic       hit_mode;
    logic       hit_status;
    logic       hit_count;
    logic       hit_any;
    logic       duty_wr;
    logic       period_hit;
    logic       duty_hit;
    logic [7:0] rd_byte;
    logic [7:0] wbyte;

    assign run = st.mode[`TMH_EN_BIT];
    assign pwm = st.mode[`TMH_PWM_BIT]; // see RULE_07

    tmh_prescaler u_prescaler (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .run_i     (run),
        .sel_i     (st.mode[`TMH_CKS_MSB:`TMH_CKS_LSB]),
        .lso_clk_i (lso_clk_i),
        .tick_o    (tick)
    );

    // Address decode; any other address answers with an error
    always_comb begin
        hit_period = apb_req_i.paddr == `TMH_ADDR_PERIOD;
        hit_duty   = apb_req_i.paddr == `TMH_ADDR_DUTY;
        hit_mode   = apb_req_i.paddr == `TMH_ADDR_MODE;
        hit_status = apb_req_i.paddr == `TMH_ADDR_STATUS;
        hit_count  = apb_req_i.paddr == `TMH_ADDR_COUNT;
        hit_any    = hit_period | hit_duty | hit_mode | hit_status | hit_count;
        setup      = apb_req_i.psel & ~apb_req_i.penable;
        wr         = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite & hit_any;
        wbyte      = apb_req_i.pwdata[7:0];
        duty_wr    = wr & hit_duty;
    end

    // Read data is latched in the setup cycle so prdata comes from a flop
    always_comb begin
        rd_byte = `TMH_RST_BYTE;
        if (hit_period) begin
            rd_byte = st.period;
        end
        if (hit_duty) begin
            rd_byte = st.duty_buf;
        end
        if (hit_mode) begin
            rd_byte = st.mode;
        end
        if (hit_status) begin
            rd_byte = {2'h0, st.pend, st.cmp, st.phase, st.active, st.pin};
        end
        if (hit_count) begin
            rd_byte = st.count;
        end
    end

    // Compare hits, only meaningful on a count clock in the run phase
    always_comb begin
        period_hit = st.count == st.period;
        duty_hit   = pwm & (st.cmp == tmh_pkg::TMH_CMP_DUTY) & (st.count == st.duty_act); // see RULE_13
    end

    always_comb begin
        next_st     = st;
        next_st.irq = 1'b0;

        // Bus side
        if (setup) begin
            next_st.slverr = ~hit_any;
            next_st.rdata  = 32'(rd_byte);
        end
        if (wr && hit_mode) begin
            next_st.mode = wbyte; // see RULE_01
        end
        if (wr && hit_period) begin
            // Not guarded: a write while running takes effect at once
            next_st.period = wbyte; // see RULE_01
        end
        if (duty_wr) begin
            next_st.duty_buf = wbyte;
            if (run) begin
                next_st.pend = 1'b1; // see RULE_03
            end else begin
                next_st.duty_act = wbyte;
                next_st.pend     = 1'b0;
            end
        end

        // Timer side
        if (!run) begin
            // Stop wipes counter, event and waveform state
            next_st.phase  = tmh_pkg::TMH_STOP; // see RULE_05
            next_st.count  = '0; // see RULE_05
            next_st.cmp    = tmh_pkg::TMH_CMP_PERIOD;
            next_st.active = 1'b0; // see RULE_16
            next_st.irq    = 1'b0; // see RULE_16
        end else begin
            case (st.phase)
                tmh_pkg::TMH_STOP: begin
                    // Prescaler starts from zero in this cycle
                    next_st.phase = tmh_pkg::TMH_ARMED;
                    next_st.count = '0;
                    next_st.cmp   = tmh_pkg::TMH_CMP_PERIOD; // see RULE_17
                end
                tmh_pkg::TMH_ARMED: begin
                    if (tick) begin
                        // First count clock is swallowed without counting
                        next_st.phase = tmh_pkg::TMH_RUN; // see RULE_22, RULE_15
                    end
                end
                tmh_pkg::TMH_RUN: begin
                    if (tick) begin
                        if (!pwm) begin
                            if (period_hit) begin
                                next_st.count  = '0; // see RULE_12
                                next_st.irq    = 1'b1; // see RULE_12, RULE_23
                                next_st.active = ~st.active; // see RULE_14
                            end else begin
                                next_st.count = st.count + 1'b1;
                            end
                        end else if (st.cmp == tmh_pkg::TMH_CMP_PERIOD) begin
                            if (period_hit) begin
                                // Counter spans 0..N, giving N+1 clocks a cycle
                                next_st.count  = '0; // see RULE_17, RULE_19
                                next_st.irq    = 1'b1; // see RULE_17, RULE_23
                                next_st.active = 1'b1; // see RULE_17
                                next_st.cmp    = tmh_pkg::TMH_CMP_DUTY; // see RULE_17
                            end else begin
                                next_st.count = st.count + 1'b1;
                            end
                        end else begin
                            if (duty_hit) begin
                                // Active over counts 0..M, M+1 clocks wide
                                next_st.active = 1'b0; // see RULE_18, RULE_19
                                next_st.cmp    = tmh_pkg::TMH_CMP_PERIOD; // see RULE_18
                                // A write in this very cycle waits for the next match
                                if (st.pend && !duty_wr) begin
                                    next_st.duty_act = st.duty_buf; // see RULE_03
                                    next_st.pend     = 1'b0;
                                end // see RULE_04
                            end
                            // Duty above period still matches at M; the period match is then missed until the counter wraps
                            next_st.count = st.count + 1'b1; // see RULE_18
                        end
                    end
                end
                default: begin
                    next_st.phase = tmh_pkg::TMH_STOP;
                end
            endcase
        end

        // Pin follows the next state so it leaves a flop
        if (next_st.mode[`TMH_OEN_BIT]) begin
            next_st.pin = next_st.mode[`TMH_LEV_BIT] ^ next_st.active; // see RULE_09, RULE_08
        end else begin
            next_st.pin = next_st.mode[`TMH_LEV_BIT]; // see RULE_24, RULE_08
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            st          <= '0; // see RULE_01
            st.mode     <= `TMH_RST_BYTE;
            st.period   <= `TMH_RST_BYTE;
            st.duty_act <= `TMH_RST_BYTE;
            st.duty_buf <= `TMH_RST_BYTE;
        end else begin
            st <= next_st;
        end
    end

    // Zero wait states: every access phase completes at once
    always_comb begin
        apb_rsp_o.prdata  = st.rdata;
        apb_rsp_o.pready  = 1'b1;
        apb_rsp_o.pslverr = st.slverr & apb_req_i.psel & apb_req_i.penable;
    end

    assign timer_out_o = st.pin;
    assign match_irq_o = st.irq;

endmodule

/* dv/tmh_timer_asserts.sv */
// Port-level checks for the interval/PWM timer
`include "tmh_defs.svh"

module tmh_timer_asserts (
    // Clock and reset
    input wire logic                  clock_i,
    input wire logic                  sys_rst_i,
    // Bus and pins
    input wire tmh_pkg::tmh_apb_req_t apb_req_i,
    input wire tmh_pkg::tmh_apb_rsp_t apb_rsp_o,
    input wire logic                  lso_clk_i,
    input wire logic                  timer_out_o,
    input wire logic                  match_irq_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] mode_q;
    logic       mode_wr;

    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    assign mode_wr = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite && apb_req_i.paddr == `TMH_ADDR_MODE;

    // Mode byte as software wrote it
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            mode_q <= 8'h00;
        end else if (mode_wr) begin
            mode_q <= apb_req_i.pwdata[7:0];
        end
    end

    sequence s_stop_wr;
        mode_wr && !apb_req_i.pwdata[`TMH_EN_BIT];
    endsequence
    // Stop acts one edge after the stored write, so look two edges on
    sequence s_quiet;
        ##2 !match_irq_o && timer_out_o == $past(apb_req_i.pwdata[`TMH_LEV_BIT], 2);
    endsequence

    property p_stop;
        s_stop_wr |-> s_quiet;
    endproperty
    property p_pulse;
        match_irq_o |=> !match_irq_o;
    endproperty
    property p_reset;
        $fell(sys_rst_i) |-> !timer_out_o && !match_irq_o;
    endproperty
    property p_off_level;
        !mode_q[`TMH_OEN_BIT] && $stable(mode_q) |-> timer_out_o == mode_q[`TMH_LEV_BIT];
    endproperty
    property p_idle;
        !mode_q[`TMH_EN_BIT] && $stable(mode_q) |-> !match_irq_o;
    endproperty
    property p_masked;
        $rose(mode_q[`TMH_EN_BIT]) |=> (!match_irq_o && timer_out_o == mode_q[`TMH_LEV_BIT]) [*2];
    endproperty
    property p_toggle;
        match_irq_o && mode_q[`TMH_OEN_BIT] && !mode_q[`TMH_PWM_BIT] |-> timer_out_o != $past(timer_out_o);
    endproperty
    property p_active;
        match_irq_o && mode_q[`TMH_OEN_BIT] && mode_q[`TMH_PWM_BIT] |-> timer_out_o == !mode_q[`TMH_LEV_BIT];
    endproperty

    a_stop:      assert property (p_stop) else $error("outputs not quiet after stop");
    a_pulse:     assert property (p_pulse) else $error("match event too long");
    a_reset:     assert property (p_reset) else $error("outputs not low after reset");
    a_off_level: assert property (p_off_level) else $error("pin not at default level");
    a_idle:      assert property (p_idle) else $error("match event while stopped");
    a_masked:    assert property (p_masked) else $error("first count clock not masked");
    a_toggle:    assert property (p_toggle) else $error("interval match did not toggle pin");
    a_active:    assert property (p_active) else $error("period match did not activate pin");
endmodule

bind tmh_timer tmh_timer_asserts chk_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .apb_req_i(apb_req_i),
    .apb_rsp_o(apb_rsp_o), .lso_clk_i(lso_clk_i), .timer_out_o(timer_out_o), .match_irq_o(match_irq_o));

/* dv/tmh_timer_test.sv */
// Self-checking bench for the interval/PWM timer
`include "tmh_defs.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
    $display("[ERR] %0t got %0h expected %0h", $time, (got), (exp)); end end

module tmh_timer_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  clock_i;
    logic                  sys_rst_i;
    logic                  lso_clk_i;
    logic                  timer_out_o;
    logic                  match_irq_o;
    tmh_pkg::tmh_apb_req_t req;
    tmh_pkg::tmh_apb_rsp_t rsp;
    logic [32:0]           exp_q[$];
    logic [32:0]           e;
    logic [31:0]           r;
    int                    n_errors;
    int                    n_tests;
    int                    dv[5] = '{1, 4, 16, 64, 4096};
    int                    g, n, m, m2;

    tmh_timer dut_u (
        .clock_i     (clock_i),
        .sys_rst_i   (sys_rst_i),
        .apb_req_i   (req),
        .apb_rsp_o   (rsp),
        .lso_clk_i   (lso_clk_i),
        .timer_out_o (timer_out_o),
        .match_irq_o (match_irq_o)
    );

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    // Slow oscillator, unrelated in phase to the bus clock
    initial begin
        lso_clk_i = 1'b0;
        forever #53 lso_clk_i = ~lso_clk_i;
    end

    // Oldest noted read result against what the slave returns
    always @(posedge clock_i) begin
        if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1) begin
            e = exp_q.pop_front();
            `CHK({rsp.pslverr, rsp.prdata}, e)
        end
    end

    task automatic wrap_up();
        $display("errors %0d, checks %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic timeout();
        n_errors++;
        $display("[ERR] %0t wait ran out", $time);
        wrap_up();
    endtask

    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int k;
        @(posedge clock_i);
        req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clock_i);
        req.penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge clock_i);
            if (rsp.pready === 1'b1) break;
        end
        req <= '0;
        if (k == 16) timeout();
    endtask

    task automatic rd(input logic [31:0] a, input logic [32:0] x);
        exp_q.push_back(x);
        apb(1'b0, a, $urandom);
    endtask

    // Width of the next full run of the pin at level v
    task automatic span(input logic v, output int w);
        int k;
        w = 0;
        for (k = 0; k < 30000 && timer_out_o !== ~v; k++) @(posedge clock_i);
        for (; k < 30000 && timer_out_o !== v; k++) @(posedge clock_i);
        for (; k < 30000 && timer_out_o === v; k++) begin
            w++;
            @(posedge clock_i);
        end
        if (k == 30000) timeout();
    endtask

    // Clock cycles from one match event to the next
    task automatic gap(output int w);
        int k;
        w = 0;
        for (k = 0; k < 30000 && match_irq_o !== 1'b1; k++) @(posedge clock_i);
        do begin
            w++;
            k++;
            @(posedge clock_i);
        end while (k < 30000 && match_irq_o !== 1'b1);
        if (k >= 30000) timeout();
    endtask

    initial begin
        req = '0;
        sys_rst_i = 1'b1;
        n_errors = 0;
        n_tests = 0;
        r = $urandom(33403);
        repeat (5) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        rd(`TMH_ADDR_PERIOD, 33'h0);
        rd(`TMH_ADDR_DUTY, 33'h0);
        rd(`TMH_ADDR_MODE, 33'h0);
        r = $urandom;
        apb(1'b1, `TMH_ADDR_PERIOD, r);
        rd(`TMH_ADDR_PERIOD, {25'h0, r[7:0]});
        apb(1'b1, `TMH_ADDR_MODE, r & 32'h7F);
        rd(`TMH_ADDR_MODE, {26'h0, r[6:0]});
        rd(32'h0000_0010, {1'b1, 32'h0});
        // Interval mode, duty left at a random value
        n = 1 + $urandom % 40;
        apb(1'b1, `TMH_ADDR_MODE, 32'h0);
        apb(1'b1, `TMH_ADDR_PERIOD, 32'(n));
        apb(1'b1, `TMH_ADDR_DUTY, $urandom % n);
        apb(1'b1, `TMH_ADDR_MODE, 32'h81);
        span(1'b1, g);
        `CHK(g, n + 1)
        span(1'b0, g);
        `CHK(g, n + 1)
        gap(g);
        `CHK(g, n + 1)
        apb(1'b1, `TMH_ADDR_MODE, 32'h01);
        for (int c = 0; c < 6; c++) begin
            apb(1'b1, `TMH_ADDR_PERIOD, 32'h1);
            apb(1'b1, `TMH_ADDR_MODE, {24'h0, 1'b1, c[2:0], 4'h1});
            span(1'b1, g);
            // Slow clock is resynchronised, so allow a little jitter
            if (c < 5) `CHK(g, 2 * dv[c])
            else `CHK(g > 2700 && g < 2730, 1'b1)
            apb(1'b1, `TMH_ADDR_MODE, {24'h0, 1'b0, c[2:0], 4'h1});
        end
        // PWM, active low, then a duty change while running
        n = 10 + $urandom % 40;
        m = $urandom % (n - 3);
        m2 = $urandom % (n - 3);
        apb(1'b1, `TMH_ADDR_MODE, 32'h0);
        apb(1'b1, `TMH_ADDR_PERIOD, 32'(n));
        apb(1'b1, `TMH_ADDR_DUTY, 32'(m));
        apb(1'b1, `TMH_ADDR_MODE, 32'h8B);
        span(1'b0, g);
        `CHK(g, m + 1)
        span(1'b1, g);
        `CHK(g, n - m)
        gap(g);
        `CHK(g, n + 1)
        span(1'b0, g);
        apb(1'b1, `TMH_ADDR_DUTY, 32'(m2));
        span(1'b0, g);
        `CHK(g, m + 1)
        span(1'b0, g);
        `CHK(g, m2 + 1)
        // Rewrite landing on the duty match: the old value serves one more pulse
        repeat (n - 3) @(posedge clock_i);
        apb(1'b1, `TMH_ADDR_DUTY, 32'(m));
        span(1'b0, g);
        `CHK(g, m2 + 1)
        span(1'b0, g);
        `CHK(g, m + 1)
        rd(`TMH_ADDR_DUTY, 33'(m));
        // Stop first, then reconfigure: interval run with the pin held off
        apb(1'b1, `TMH_ADDR_MODE, 32'h0B);
        apb(1'b1, `TMH_ADDR_MODE, 32'h82);
        gap(g);
        `CHK(g, n + 1)
        `CHK(timer_out_o, 1'b1)
        apb(1'b1, `TMH_ADDR_MODE, 32'h02);
        rd(`TMH_ADDR_COUNT, 33'h0);
        wrap_up();
    end
endmodule
